/* File: capture_compare.sv */
/*
 * Capture/compare unit with a classic Wishbone register slave: mode decode,
 * capture of the timer-one count, compare actions and the event flag.
 * Assumes timer-one count arrives synchronous to clk and the pin is async.
 */
// Functional notes
// - Control bits 7-6 read as zero
// - Control bits 5-4 hold duty low bits
// - Codes 4-7 select capture edge and prescale
// - Code 1010 sets flag, pin untouched
// - Code 1011 sets flag, resets timer
// - Capture copies full 16-bit timer count
// - Every capture sets event flag bit two
// - New capture overwrites old, no overrun
// - Port write as output may capture
// - Mode change may raise spurious flag
// - Prescaler cleared when off, non-capture, reset
// - Prescaler change keeps counter uncleared
// - Trigger clears timer, starts conversion, no overflow
`default_nettype none
module capture_compare
    import capture_compare_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [capture_compare_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [15:0] timer_one_count,
    input wire logic converter_enabled,
    input wire logic unit_pin_i,
    output logic unit_pin_o,
    output logic unit_pin_oe_n,
    output logic timer_one_clear,
    output logic conversion_start,
    output logic capture_event_irq
);
    logic [5:0] control_r;
    logic [15:0] capture_register_pair;
    logic capture_event_flag;
    logic capture_event_irq_enable;
    logic port_c_direction;
    logic port_data_r;
    logic compare_latch_r;
    logic cap_event;
    logic pin_level;
    logic [3:0] unit_mode_field;
    logic is_compare;
    logic match;
    logic match_last_r;
    logic match_rise;
    logic wr;
    logic rd;
    logic req;
    logic [31:0] rd_data;

    function automatic logic sel_hits(input logic [ADDR_W-1:0] adr, input logic [7:0] off);
        sel_hits = (adr[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction

    assign unit_mode_field = control_r[CTRL_MODE_MSB:CTRL_MODE_LSB];
    assign is_compare = (unit_mode_field[3:2] == 2'b10);
    assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr = req & wb_we_i & wb_sel_i[0] & ce;
    assign rd = req & ~wb_we_i;
    assign match = is_compare && (timer_one_count == capture_register_pair);
    assign match_rise = match & ~match_last_r;
    // When the pin is driven, the edge detector sees the driven level
    assign pin_level = port_c_direction ? unit_pin_i : unit_pin_o;

    edge_qualifier u_edge (
        .clk(clk),
        .srst(srst),
        .ce(ce),
        .pin_async(pin_level),
        .mode(unit_mode_field),
        .event_pulse(cap_event)
    );

    // Bus answer takes one cycle; ack drops the cycle after
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else if (ce)
        begin
            wb_ack_o <= req;
            wb_dat_o <= rd ? rd_data : 32'h0000_0000;
        end
    end

    always_comb
    begin
        rd_data = 32'h0000_0000;
        if (sel_hits(wb_adr_i, OFF_CONTROL))
            rd_data = {24'h00_0000, 2'b00, control_r};
        else if (sel_hits(wb_adr_i, OFF_CAPTURE_LOW))
            rd_data = {24'h00_0000, capture_register_pair[7:0]};
        else if (sel_hits(wb_adr_i, OFF_CAPTURE_HIGH))
            rd_data = {24'h00_0000, capture_register_pair[15:8]};
        else if (sel_hits(wb_adr_i, OFF_FLAGS))
            rd_data = {29'h0000_0000, capture_event_flag, 2'b00};
        else if (sel_hits(wb_adr_i, OFF_IRQ_ENABLE))
            rd_data = {29'h0000_0000, capture_event_irq_enable, 2'b00};
        else if (sel_hits(wb_adr_i, OFF_TIMER_LOW))
            rd_data = {24'h00_0000, timer_one_count[7:0]};
        else if (sel_hits(wb_adr_i, OFF_TIMER_HIGH))
            rd_data = {24'h00_0000, timer_one_count[15:8]};
        else if (sel_hits(wb_adr_i, OFF_PORT))
            rd_data = {29'h0000_0000, port_c_direction, 1'b0, port_data_r};
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            control_r <= CONTROL_RESET[5:0];
        else if (wr && sel_hits(wb_adr_i, OFF_CONTROL))
            control_r <= wb_dat_i[5:0] & CONTROL_IMPL_MASK[5:0];
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            capture_event_irq_enable <= 1'b0;
            port_c_direction <= 1'b1;
            port_data_r <= 1'b0;
        end
        else if (wr)
        begin
            if (sel_hits(wb_adr_i, OFF_IRQ_ENABLE))
                capture_event_irq_enable <= wb_dat_i[FLAG_EVENT_BIT];
            if (sel_hits(wb_adr_i, OFF_PORT))
            begin
                port_c_direction <= wb_dat_i[PORT_DIR_BIT];
                port_data_r <= wb_dat_i[0];
            end
        end
    end

    // Capture register pair: written by capture, or by software in any mode; capture wins
    always_ff @(posedge clk)
    begin
        if (srst)
            capture_register_pair <= 16'h0000;
        else if (ce && cap_event)
            capture_register_pair <= timer_one_count;
        else if (wr && sel_hits(wb_adr_i, OFF_CAPTURE_LOW))
            capture_register_pair[7:0] <= wb_dat_i[7:0];
        else if (wr && sel_hits(wb_adr_i, OFF_CAPTURE_HIGH))
            capture_register_pair[15:8] <= wb_dat_i[7:0];
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            match_last_r <= 1'b0;
        else if (ce)
            match_last_r <= match;
    end

    // Flag set wins over a software clear in the same cycle; a mode change may
    // itself create a capture edge, which is the documented spurious flag
    always_ff @(posedge clk)
    begin
        if (srst)
            capture_event_flag <= 1'b0;
        else if (ce && (cap_event || match_rise))
            capture_event_flag <= 1'b1;
        else if (wr && sel_hits(wb_adr_i, OFF_FLAGS))
            capture_event_flag <= wb_dat_i[FLAG_EVENT_BIT];
    end

    always_ff @(posedge clk)
    begin
        if (srst || unit_mode_field == MODE_OFF)
            compare_latch_r <= 1'b0;
        else if (ce && match_rise)
        begin
            if (unit_mode_field == MODE_CMP_SET)
                compare_latch_r <= 1'b1;
            else if (unit_mode_field == MODE_CMP_CLEAR)
                compare_latch_r <= 1'b0;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            unit_pin_o <= 1'b0;
            unit_pin_oe_n <= 1'b1;
        end
        else if (ce)
        begin
            unit_pin_oe_n <= port_c_direction;
            if (unit_mode_field == MODE_CMP_SET || unit_mode_field == MODE_CMP_CLEAR)
                unit_pin_o <= compare_latch_r;
            else
                unit_pin_o <= port_data_r;
        end
    end

    // Trigger pulse never touches any overflow flag; clears the count and, if the converter is enabled, starts a conversion
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            timer_one_clear <= 1'b0;
            conversion_start <= 1'b0;
        end
        else
        begin
            timer_one_clear <= ce && match_rise && unit_mode_field == MODE_CMP_TRIG;
            conversion_start <= ce && match_rise && unit_mode_field == MODE_CMP_TRIG && converter_enabled;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            capture_event_irq <= 1'b0;
        else if (ce)
            capture_event_irq <= capture_event_flag & capture_event_irq_enable;
    end
endmodule
`default_nettype wire

/* File: capture_compare_pkg.sv */
/*
 * Shared constants for the capture/compare unit: Wishbone register map,
 * control field layout, mode codes and reset values.
 * Assumes a 32-bit classic Wishbone slave with word-aligned registers.
 */
`default_nettype none
package capture_compare_pkg;
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_CONTROL = 8'h00;
    localparam logic [7:0] OFF_CAPTURE_LOW = 8'h04;
    localparam logic [7:0] OFF_CAPTURE_HIGH = 8'h08;
    localparam logic [7:0] OFF_FLAGS = 8'h0C;
    localparam logic [7:0] OFF_IRQ_ENABLE = 8'h10;
    localparam logic [7:0] OFF_TIMER_LOW = 8'h14;
    localparam logic [7:0] OFF_TIMER_HIGH = 8'h18;
    localparam logic [7:0] OFF_PORT = 8'h1C;

    localparam int CTRL_MODE_LSB = 0;
    localparam int CTRL_MODE_MSB = 3;
    localparam int CTRL_DUTY_LSB = 4;
    localparam int CTRL_DUTY_MSB = 5;
    localparam int FLAG_EVENT_BIT = 2;
    localparam int PORT_DIR_BIT = 2;

    localparam logic [7:0] CONTROL_RESET = 8'h00;
    localparam logic [7:0] CONTROL_IMPL_MASK = 8'h3F;
    localparam logic [3:0] MODE_OFF = 4'h0;
    localparam logic [3:0] MODE_CAP_FALL = 4'h4;
    localparam logic [3:0] MODE_CAP_RISE = 4'h5;
    localparam logic [3:0] MODE_CAP_RISE4 = 4'h6;
    localparam logic [3:0] MODE_CAP_RISE16 = 4'h7;
    localparam logic [3:0] MODE_CMP_SET = 4'h8;
    localparam logic [3:0] MODE_CMP_CLEAR = 4'h9;
    localparam logic [3:0] MODE_CMP_SOFT = 4'hA;
    localparam logic [3:0] MODE_CMP_TRIG = 4'hB;
    localparam logic [3:0] PRESCALE_4_LAST = 4'h3;
    localparam logic [3:0] PRESCALE_16_LAST = 4'hF;
endpackage
`default_nettype wire

/* File: capture_compare_properties.sv */
/* Checker for the capture/compare bus slave and trigger pulses.
   Assumes it is bound onto capture_compare, one clock domain. */
`default_nettype none
module capture_compare_properties
    import capture_compare_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [capture_compare_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    input wire logic converter_enabled,
    input wire logic unit_pin_oe_n,
    input wire logic timer_one_clear,
    input wire logic conversion_start,
    input wire logic capture_event_irq
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);
    chk_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o)
        else $error("request not acked");
    chk_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    chk_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    chk_ctrl_top: assert property ($past(!wb_we_i && wb_adr_i == OFF_CONTROL) && wb_ack_o
        |-> wb_dat_o[31:6] == 26'h0) else $error("control upper bits set");
    chk_unmapped_zero: assert property ($past(!wb_we_i && wb_adr_i >= 8'h20) && wb_ack_o
        |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
    chk_clear_single: assert property (timer_one_clear |=> !timer_one_clear)
        else $error("timer clear pulse too long");
    chk_conv_gate: assert property (conversion_start |-> timer_one_clear && $past(converter_enabled))
        else $error("conversion start without trigger");
    chk_ce_freeze: assert property (!ce && !wb_ack_o |=> !wb_ack_o)
        else $error("ack while clock enable low");
    chk_reset_quiet: assert property (disable iff (1'b0) srst |=> !wb_ack_o && unit_pin_oe_n
        && !timer_one_clear && !capture_event_irq) else $error("outputs active after reset");
    cover property (timer_one_clear);
    cover property (capture_event_irq);
    cover property (wb_ack_o && !ce);
endmodule
bind capture_compare capture_compare_properties capture_compare_properties_inst (.*);
`default_nettype wire

/* File: edge_qualifier.sv */
/*
 * Pin synchroniser and capture edge qualifier with prescaler counter.
 * Assumes the pin is asynchronous to clk; mode code comes from clk domain.
 */
`default_nettype none
module edge_qualifier
    import capture_compare_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic ce,
    input wire logic pin_async,
    input wire logic [3:0] mode,
    output logic event_pulse
);
    logic sync1_r;
    logic sync2_r;
    logic last_r;
    logic [3:0] presc_r;
    logic is_capture;
    logic rise;
    logic fall;

    assign is_capture = (mode[3:2] == 2'b01);
    assign rise = sync2_r & ~last_r;
    assign fall = ~sync2_r & last_r;

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
            last_r <= 1'b0;
        end
        else if (ce)
        begin
            sync1_r <= pin_async;
            sync2_r <= sync1_r;
            last_r <= sync2_r;
        end
    end

    // Counter is kept across prescaler changes, so an early capture can follow one
    always_ff @(posedge clk)
    begin
        if (srst || !is_capture)
        begin
            presc_r <= 4'h0;
        end
        else if (ce && rise && (mode == MODE_CAP_RISE4 || mode == MODE_CAP_RISE16))
        begin
            presc_r <= presc_r + 4'h1;
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            event_pulse <= 1'b0;
        end
        else if (ce)
        begin
            case (mode)
                MODE_CAP_FALL: event_pulse <= fall;
                MODE_CAP_RISE: event_pulse <= rise;
                MODE_CAP_RISE4: event_pulse <= rise && presc_r[1:0] == PRESCALE_4_LAST[1:0];
                MODE_CAP_RISE16: event_pulse <= rise && presc_r == PRESCALE_16_LAST;
                default: event_pulse <= 1'b0;
            endcase
        end
        else
        begin
            event_pulse <= 1'b0;
        end
    end
endmodule
`default_nettype wire

/* File: pin_source.sv */
/* Partner model: external digital source on the capture pin.
   Assumes its tasks are called right after a rising clk edge. */
`default_nettype none
module pin_source
(
    input wire logic clk,
    output var logic pin
);
    timeunit 1ns;
    timeprecision 1ps;
    initial pin = 1'b0;
    // Each level stands 4 cycles so the synchroniser cannot miss it
    task automatic level(input logic v);
        pin <= v;
        repeat (4) @(posedge clk);
    endtask
    task automatic pulses(input int n);
        repeat (n)
        begin
            level(1'b1);
            level(1'b0);
        end
    endtask
endmodule
`default_nettype wire

/* File: tb_top.sv */
/* Self-checking bench for capture_compare with a pin source partner.
   Assumes the checker is bound through its own file. */
`default_nettype none
module tb_top;
    import capture_compare_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} row_s;
    logic clk = 1'b0, srst = 1'b1, ce = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic pin, pin_o, pin_oe_n, clr, conv, irq, ack;
    logic [7:0] adr = 8'h00;
    logic [31:0] dat = 32'h0, dat_o, q;
    logic [3:0] sel = 4'hF;
    logic conv_en = 1'b1;
    // Timer count changes only on clk edges
    logic [15:0] tmr = 16'hA5C3;
    int err_total = 0, compares = 0, clr_cnt = 0, conv_cnt = 0;
    row_s rows [9] = '{'{1'b1, OFF_CONTROL, 32'hFF, 32'h0}, '{1'b0, OFF_CONTROL, 32'h0, 32'h3F},
        '{1'b1, OFF_IRQ_ENABLE, 32'hFF, 32'h0}, '{1'b0, OFF_IRQ_ENABLE, 32'h0, 32'h4},
        '{1'b1, OFF_TIMER_LOW, 32'h55, 32'h0}, '{1'b0, OFF_TIMER_LOW, 32'h0, 32'hC3},
        '{1'b0, OFF_TIMER_HIGH, 32'h0, 32'hA5}, '{1'b0, 8'h20, 32'h0, 32'h0}, '{1'b1, OFF_CONTROL, 32'h0, 32'h0}};
    capture_compare capture_compare_inst (.clk(clk), .srst(srst), .ce(ce), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .timer_one_count(tmr), .converter_enabled(conv_en), .unit_pin_i(pin), .unit_pin_o(pin_o),
        .unit_pin_oe_n(pin_oe_n), .timer_one_clear(clr), .conversion_start(conv), .capture_event_irq(irq));
    pin_source pin_source_inst (.clk(clk), .pin(pin));
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk)
    begin
        clr_cnt += (clr === 1'b1);
        conv_cnt += (conv === 1'b1);
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        compares++;
        if (s !== e)
        begin
            err_total++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        dat <= d;
        @(posedge clk);
        while (ack !== 1'b1 && n < 20)
        begin
            @(posedge clk);
            n++;
        end
        err_total += (n == 20);
        q = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        chk(q, e);
    endtask
    task automatic flag_is(input logic f);
        rd(OFF_FLAGS, {29'h0, f, 2'h0});
    endtask
    task automatic cap_is(input logic [15:0] t);
        tick(8);
        rd(OFF_CAPTURE_LOW, {24'h0, t[7:0]});
        rd(OFF_CAPTURE_HIGH, {24'h0, t[15:8]});
    endtask
    task automatic mode(input logic [3:0] m);
        wb(1'b1, OFF_CONTROL, 32'h0);
        wb(1'b1, OFF_CONTROL, {28'h0, m});
        wb(1'b1, OFF_FLAGS, 32'h0);
    endtask
    task automatic tally_and_finish;
        if (err_total == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        tick(3);
        srst <= 1'b0;
        tick(1);
        foreach (rows[i])
        begin
            if (rows[i].w)
                wb(1'b1, rows[i].a, rows[i].d);
            else
                rd(rows[i].a, rows[i].e);
        end
        tmr <= 16'h1234;
        mode(MODE_CAP_RISE); // Pin still an input from reset
        pin_source_inst.pulses(1);
        cap_is(16'h1234);
        flag_is(1'b1);
        chk({31'h0, irq}, 32'h1);
        tmr <= 16'hBEEF;
        pin_source_inst.pulses(1);
        cap_is(16'hBEEF);
        flag_is(1'b1);
        wb(1'b1, OFF_FLAGS, 32'h0);
        chk({31'h0, irq}, 32'h0);
        mode(MODE_CAP_FALL);
        tmr <= 16'h0F0F;
        pin_source_inst.level(1'b1);
        flag_is(1'b0);
        pin_source_inst.level(1'b0);
        cap_is(16'h0F0F);
        for (int i = 0; i < 2; i++)
        begin
            mode(i ? MODE_CAP_RISE16 : MODE_CAP_RISE4);
            pin_source_inst.pulses(i ? 15 : 3);
            flag_is(1'b0);
            pin_source_inst.pulses(1);
            flag_is(1'b1);
        end
        mode(MODE_CAP_RISE4);
        pin_source_inst.pulses(2);
        mode(MODE_CAP_RISE4);
        pin_source_inst.pulses(3);
        flag_is(1'b0);
        pin_source_inst.pulses(1);
        flag_is(1'b1);
        mode(MODE_CAP_RISE);
        wb(1'b1, OFF_PORT, 32'h0);
        wb(1'b1, OFF_PORT, 32'h1);
        tick(6);
        flag_is(1'b1);
        chk({30'h0, pin_o, pin_oe_n}, 32'h2);
        for (int i = 0; i < 4; i++)
        begin
            tmr <= 16'h0;
            mode(MODE_CMP_SET + 4'(i));
            wb(1'b1, OFF_CAPTURE_LOW, 32'h34);
            wb(1'b1, OFF_CAPTURE_HIGH, 32'h12);
            clr_cnt = 0;
            conv_cnt = 0;
            tmr <= 16'h1234;
            tick(6);
            flag_is(1'b1);
            chk(clr_cnt, i == 3);
            chk(conv_cnt, i == 3);
            if (i < 2)
                chk(pin_o, i == 0);
        end
        // Trigger with the converter disabled: timer still cleared, no conversion
        tmr <= 16'h0;
        conv_en <= 1'b0;
        mode(MODE_CMP_TRIG);
        clr_cnt = 0;
        conv_cnt = 0;
        tmr <= 16'h1234;
        tick(6);
        chk(clr_cnt, 32'h1);
        chk(conv_cnt, 32'h0);
        conv_en <= 1'b1;
        // A write without the low byte lane selected must not land
        sel <= 4'h0;
        wb(1'b1, OFF_CONTROL, 32'h5);
        sel <= 4'hF;
        rd(OFF_CONTROL, {28'h0, MODE_CMP_TRIG});
        ce <= 1'b0;
        tick(3);
        ce <= 1'b1;
        srst <= 1'b1;
        tick(3);
        srst <= 1'b0;
        tick(1);
        rd(OFF_CONTROL, 32'h0);
        rd(OFF_PORT, 32'h4);
        flag_is(1'b0);
        tally_and_finish();
    end
    initial
    begin
        #20000;
        err_total++;
        tally_and_finish();
    end
endmodule
`default_nettype wire
